// *** inc/network_time_sync_pkg.sv ***
// Purpose: constants for the network time sync monitor
// Assumes: 20 MHz clock, 8-bit host register port
// Notes:   rule summary below
// Overview of operation
// - receive lag grows with slower bit rate, doubling per rate-select step
// - a built-in rate-dependent offset is added to received master time
// - config bit 15 picks offset source: 0 automatic (default), 1 manual
// - manual offset value is config bits 12 to 8, range 0 to 31
// - manual offset time equals value times one time resolution step
// - standalone mode or prescale msb low forces the automatic offset
// - sync flag sits in interrupt status; standalone drives it on interrupt pin
// - sync flag: 0 locked, 1 unlocked, reset value 1
// - slave flag clears only after three consecutive receptions within +/-2
// - flag sets when a reception difference falls outside +/-2
// - peripheral mode: flag stays 1 until master id written and node is master
// - software reset holds flag 1 on master, 0 once id is in place
// - standalone master by pins: flag 1 in hardware reset, 0 after
// - phase register bit 15: 0 local ahead, 1 local behind
// - phase register bits 14 to 0 hold difference magnitude
// - even byte read latches upper byte for the following odd read
// - carry period is resolution times two to the digit select plus one
// - slave slows counter at diff +2 or more, speeds at -1 or less
// - carry pulse is low for exactly one resolution step
package network_time_sync_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PHASE_LO_ADDR  = 8'h32;
    localparam logic [7:0] PHASE_HI_ADDR  = 8'h33;
    localparam logic [7:0] CARRY_LO_ADDR  = 8'h34;
    localparam logic [7:0] CARRY_HI_ADDR  = 8'h35;
    localparam logic [7:0] MASTER_ID_ADDR = 8'h36;
    localparam logic [7:0] INT_STAT_ADDR  = 8'h37;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int OFS_SEL_BIT = 15;
    localparam int OFS_VAL_HI  = 12;
    localparam int OFS_VAL_LO  = 8;
    localparam int UNLOCK_BIT  = 0;
    localparam logic [15:0] CARRY_RESET = 16'h0000;
    localparam logic [4:0]  MASTER_ID_RESET = 5'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ      = 20000;
    localparam int BASE_LAG_NS  = 22000;
    localparam int BASE_LAG_CYC = BASE_LAG_NS * CLK_KHZ / 1000000;
    localparam int PRESCALE_LOG2_MIN = 5;
    localparam int LOCK_COUNT   = 3;
    localparam int WIN_LIMIT    = 2;
endpackage

// *** design/network_time_sync_monitor.sv ***
// Purpose: network time counter, offset, lock flag, phase and carry
// Assumes: receive logic on clk delivers master packets as pulses
// Notes:   pins from off-chip pass two flip-flops before use
`timescale 1ns/100ps
`default_nettype none
module network_time_sync_monitor
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       swReset,
    input  wire logic       standaloneMode,
    input  wire logic [4:0] nodeId,
    input  wire logic [4:0] masterIdPins,
    input  wire logic [3:0] carryDigitPins,
    input  wire logic [2:0] bitRateSelect,
    input  wire logic [2:0] timePrescaleSel,
    input  wire logic       rxValid,
    input  wire logic [4:0] rxSrcId,
    input  wire logic [15:0] rxTime,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [7:0] regWrData,
    output logic [7:0]      regRdData,
    output logic [15:0]     networkTime,
    output logic            syncUnlockFlag,
    output logic            interruptOutN,
    output logic            timeCarryPulseN
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [14:0] pinMeta_reg;
    logic [14:0] pinSync_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta_reg <= 15'h0000;
            pinSync_reg <= 15'h0000;
        end
        else
        begin
            pinMeta_reg <= {standaloneMode, nodeId, masterIdPins, carryDigitPins};
            pinSync_reg <= pinMeta_reg;
        end
    end
    logic       standS;
    logic [4:0] nodeIdS;
    logic [4:0] idPinsS;
    logic [3:0] digitPinsS;
    assign {standS, nodeIdS, idPinsS, digitPinsS} = pinSync_reg;

    // ------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------
    logic [15:0] carryCfg_reg;
    logic [4:0]  masterId_reg;
    logic        idValid_reg;
    logic [15:0] phase_reg;
    logic [7:0]  phaseHiLatch_reg;
    logic        unlock_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            carryCfg_reg <= network_time_sync_pkg::CARRY_RESET;
        else if (regWr && regAddr == network_time_sync_pkg::CARRY_LO_ADDR)
            carryCfg_reg[7:0] <= regWrData;
        else if (regWr && regAddr == network_time_sync_pkg::CARRY_HI_ADDR)
            carryCfg_reg[15:8] <= regWrData;
    end

    // software reset keeps the id; the lock logic forces unlock while it lasts
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            masterId_reg <= network_time_sync_pkg::MASTER_ID_RESET;
            idValid_reg  <= 1'b0;
        end
        else if (regWr && regAddr == network_time_sync_pkg::MASTER_ID_ADDR)
        begin
            masterId_reg <= regWrData[4:0];
            idValid_reg  <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regRdData        <= 8'h00;
            phaseHiLatch_reg <= 8'h00;
        end
        else if (regRd)
        begin
            if (regAddr == network_time_sync_pkg::PHASE_LO_ADDR)
            begin
                regRdData        <= phase_reg[7:0];
                phaseHiLatch_reg <= phase_reg[15:8];
            end
            else if (regAddr == network_time_sync_pkg::PHASE_HI_ADDR)
                regRdData <= phaseHiLatch_reg;
            else if (regAddr == network_time_sync_pkg::CARRY_LO_ADDR)
                regRdData <= carryCfg_reg[7:0];
            else if (regAddr == network_time_sync_pkg::CARRY_HI_ADDR)
                regRdData <= carryCfg_reg[15:8];
            else if (regAddr == network_time_sync_pkg::MASTER_ID_ADDR)
                regRdData <= {3'h0, masterId_reg};
            else if (regAddr == network_time_sync_pkg::INT_STAT_ADDR)
                regRdData <= {7'h00, unlock_reg};
            else
                regRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // master identity
    // ------------------------------------------------------------
    logic [4:0] masterEff;
    logic       idKnown;
    logic       isMaster;
    assign masterEff = standS ? idPinsS : masterId_reg;
    assign idKnown   = standS || idValid_reg;
    assign isMaster  = idKnown && (masterEff == nodeIdS);

    // ------------------------------------------------------------
    // prescaler and local time counter
    // ------------------------------------------------------------
    logic [11:0] preCnt_reg;
    logic [11:0] preMax;
    logic        tick;
    assign preMax = 12'((32'd1 << (network_time_sync_pkg::PRESCALE_LOG2_MIN
                    + 32'(timePrescaleSel))) - 32'd1);
    assign tick   = (preCnt_reg >= preMax); // >= so a smaller prescale never waits a wrap

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            preCnt_reg <= 12'h000;
        else if (swReset || tick)
            preCnt_reg <= 12'h000;
        else
            preCnt_reg <= preCnt_reg + 12'h001;
    end

    // ------------------------------------------------------------
    // offset selection
    // ------------------------------------------------------------
    logic [15:0] autoOffset;
    logic [15:0] manualOffset;
    logic        manualSel;
    logic [15:0] offsetVal;
    // lag in clocks over clocks per step; truncation keeps the lag short
    assign autoOffset = 16'((network_time_sync_pkg::BASE_LAG_CYC
                        << bitRateSelect) >> (network_time_sync_pkg::PRESCALE_LOG2_MIN
                        + 32'(timePrescaleSel)));
    assign manualOffset = {11'h000, carryCfg_reg[network_time_sync_pkg::OFS_VAL_HI:
                           network_time_sync_pkg::OFS_VAL_LO]};
    assign manualSel = carryCfg_reg[network_time_sync_pkg::OFS_SEL_BIT]
                       && !standS && timePrescaleSel[2];
    assign offsetVal = manualSel ? manualOffset : autoOffset;

    // ------------------------------------------------------------
    // phase comparison
    // ------------------------------------------------------------
    logic        rxHit;
    logic [15:0] diff;
    logic [15:0] absDiff;
    logic        inWin;
    logic        diffGe2;
    logic        diffLeM1;
    assign rxHit = rxValid && idKnown && !isMaster && (rxSrcId == masterEff);
    assign diff  = networkTime - (rxTime + offsetVal);
    assign absDiff = diff[15] ? (16'h0000 - diff) : diff;
    assign inWin = (16'(diff + 16'(network_time_sync_pkg::WIN_LIMIT))
                   <= 16'(2 * network_time_sync_pkg::WIN_LIMIT));
    assign diffGe2  = !diff[15] && (diff >= 16'h0002);
    assign diffLeM1 = diff[15];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase_reg <= 16'h0000;
        else if (rxHit)
            phase_reg <= {diff[15], absDiff[14:0]};
    end

    // pending correction is applied on the next counter step
    logic slowPend_reg;
    logic fastPend_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slowPend_reg <= 1'b0;
            fastPend_reg <= 1'b0;
        end
        else if (swReset)
        begin
            slowPend_reg <= 1'b0;
            fastPend_reg <= 1'b0;
        end
        else if (rxHit)
        begin
            slowPend_reg <= diffGe2;
            fastPend_reg <= diffLeM1;
        end
        else if (tick)
        begin
            slowPend_reg <= 1'b0;
            fastPend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            networkTime <= 16'h0000;
        else if (swReset)
            networkTime <= 16'h0000;
        else if (tick && !slowPend_reg)
            networkTime <= networkTime + (fastPend_reg ? 16'h0002 : 16'h0001);
    end

    // ------------------------------------------------------------
    // lock tracking
    // ------------------------------------------------------------
    logic [1:0] winCnt_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            winCnt_reg <= 2'h0;
        else if (swReset)
            winCnt_reg <= 2'h0;
        else if (rxHit)
            winCnt_reg <= inWin ? ((winCnt_reg == 2'h3) ? 2'h3 : winCnt_reg + 2'h1)
                                : 2'h0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            unlock_reg <= 1'b1;
        else if (swReset)
            unlock_reg <= 1'b1;
        else if (isMaster)
            unlock_reg <= 1'b0;
        else if (rxHit && !inWin)
            unlock_reg <= 1'b1;
        else if (rxHit && winCnt_reg >= 2'(network_time_sync_pkg::LOCK_COUNT - 1))
            unlock_reg <= 1'b0;
    end
    assign syncUnlockFlag = unlock_reg;
    assign interruptOutN  = standS ? unlock_reg : 1'b1;

    // ------------------------------------------------------------
    // carry output
    // ------------------------------------------------------------
    logic [3:0]  digitSel;
    logic [15:0] digitMask;
    logic        carryZero;
    assign digitSel  = standS ? digitPinsS : carryCfg_reg[3:0];
    assign digitMask = 16'((32'd2 << digitSel) - 32'd1);
    assign carryZero = ((networkTime & digitMask) == 16'h0000);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            timeCarryPulseN <= 1'b1;
        else
            timeCarryPulseN <= !carryZero;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_swreset_unlock;
        @(posedge clk) disable iff (rst) swReset |=> unlock_reg;
    endproperty
    a_swreset_unlock: assert property (p_swreset_unlock)
        else $error("unlock flag not set after software reset");

    property p_outside_unlock;
        @(posedge clk) disable iff (rst)
        (rxHit && !inWin && !swReset) |=> unlock_reg;
    endproperty
    a_outside_unlock: assert property (p_outside_unlock)
        else $error("out of window reception left flag clear");

    property p_master_lock;
        @(posedge clk) disable iff (rst) (isMaster && !swReset) |=> !unlock_reg;
    endproperty
    a_master_lock: assert property (p_master_lock)
        else $error("master node not locked");

    property p_lock_needs_three;
        @(posedge clk) disable iff (rst)
        $fell(unlock_reg) |-> ($past(isMaster) || ($past(winCnt_reg) >= 2'h2
                               && $past(rxHit) && $past(inWin)));
    endproperty
    a_lock_needs_three: assert property (p_lock_needs_three)
        else $error("locked without three good receptions");

    property p_dir_ahead;
        @(posedge clk) disable iff (rst) (rxHit && !diff[15]) |=> !phase_reg[15];
    endproperty
    a_dir_ahead: assert property (p_dir_ahead)
        else $error("direction wrong for local ahead");

    property p_phase_hold;
        @(posedge clk) disable iff (rst) !rxHit |=> $stable(phase_reg);
    endproperty
    a_phase_hold: assert property (p_phase_hold)
        else $error("phase register changed without packet");

    property p_auto_forced;
        @(posedge clk) disable iff (rst)
        (standS || !timePrescaleSel[2]) |-> (offsetVal == autoOffset);
    endproperty
    a_auto_forced: assert property (p_auto_forced)
        else $error("manual offset used where forbidden");

    property p_hi_latch;
        @(posedge clk) disable iff (rst)
        (regRd && regAddr == network_time_sync_pkg::PHASE_LO_ADDR)
        |=> phaseHiLatch_reg == $past(phase_reg[15:8]);
    endproperty
    a_hi_latch: assert property (p_hi_latch)
        else $error("upper phase byte not latched");

    property p_carry_cause;
        @(posedge clk) disable iff (rst) $fell(timeCarryPulseN) |-> $past(carryZero);
    endproperty
    a_carry_cause: assert property (p_carry_cause)
        else $error("carry pulse without digit rollover");
endmodule
`default_nettype wire

// *** dv/time_master_model.sv ***
// Purpose: time master node seen from a slave, sends time packets
// Assumes: one packet at a time, sent on request of the bench
// Notes:   idle data lines carry inverted values, never a stale time
`timescale 1ns/100ps
`default_nettype none
module time_master_model
(
    input  wire logic        clk,
    input  wire logic [15:0] networkTime,
    output var  logic        rxValid,
    output var  logic [4:0]  rxSrcId,
    output var  logic [15:0] rxTime
);
    initial
    begin
        rxValid = 1'b0;
        rxSrcId = 5'h00;
        rxTime  = 16'h0000;
    end

    // wait for a fresh local step so the taking edge sees the same local time
    task automatic send(input logic [4:0] src, input int off, input int delta);
        logic [15:0] t;
        @(posedge clk);
        t = networkTime;
        @(posedge clk);
        while (networkTime === t)
            @(posedge clk);
        rxTime  <= networkTime - 16'(off + delta);
        rxSrcId <= src;
        rxValid <= 1'b1;
        @(posedge clk);
        rxValid <= 1'b0;
        rxTime  <= ~rxTime;
        rxSrcId <= ~src;
    endtask
endmodule
`default_nettype wire

// *** dv/test_network_time_sync_monitor.sv ***
// Purpose: self-checking bench for the time sync monitor
// Assumes: 20 MHz clock, prescale 000 gives 32 clocks per step
// Notes:   node id 3, master id 5 unless a scenario makes the node master
`timescale 1ns/100ps
`default_nettype none
module test_network_time_sync_monitor;
    logic        clk;
    logic        rst;
    logic        swReset;
    logic        standaloneMode;
    logic [4:0]  masterIdPins;
    logic [3:0]  carryDigitPins;
    logic [2:0]  bitRateSelect;
    logic [2:0]  timePrescaleSel;
    logic        rxValid;
    logic [4:0]  rxSrcId;
    logic [15:0] rxTime;
    logic [7:0]  regAddr;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    logic [15:0] networkTime;
    logic        syncUnlockFlag;
    logic        interruptOutN;
    logic        timeCarryPulseN;
    logic [7:0]  d;
    int          errors;
    int          comparisons;

    network_time_sync_monitor u_network_time_sync_monitor
    (
        .clk(clk), .rst(rst), .swReset(swReset), .standaloneMode(standaloneMode),
        .nodeId(5'h03), .masterIdPins(masterIdPins), .carryDigitPins(carryDigitPins),
        .bitRateSelect(bitRateSelect), .timePrescaleSel(timePrescaleSel),
        .rxValid(rxValid), .rxSrcId(rxSrcId), .rxTime(rxTime),
        .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
        .regRdData(regRdData), .networkTime(networkTime),
        .syncUnlockFlag(syncUnlockFlag), .interruptOutN(interruptOutN),
        .timeCarryPulseN(timeCarryPulseN)
    );

    time_master_model u_time_master_model
    (
        .clk(clk), .networkTime(networkTime), .rxValid(rxValid),
        .rxSrcId(rxSrcId), .rxTime(rxTime)
    );

    always #25 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic read_phase(input logic [15:0] exp);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(network_time_sync_pkg::PHASE_LO_ADDR, lo);
        rd(network_time_sync_pkg::PHASE_HI_ADDR, hi);
        check("phase", {hi, lo}, exp);
    endtask

    // automatic offset in steps: base lag doubled per rate code over step length
    function automatic int auto_ofs(input int r, input int p);
        return (network_time_sync_pkg::BASE_LAG_CYC << r)
            / ((1 << network_time_sync_pkg::PRESCALE_LOG2_MIN) << p);
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("unlock", syncUnlockFlag, 1);
        check("intOut", interruptOutN, 1);
        rd(network_time_sync_pkg::INT_STAT_ADDR, d);
        check("intStat", d, 8'h01);
        rd(network_time_sync_pkg::CARRY_HI_ADDR, d);
        check("cfgHi", d, network_time_sync_pkg::CARRY_RESET[15:8]);
        rd(8'h40, d);
        check("unmapped", d, 0);
    endtask

    // one whole carry cycle, sampled just after each edge: clocks low, then fall to fall
    task automatic carry_span(output int lo, output int per);
        lo = 0;
        per = 0;
        while (timeCarryPulseN !== 1'b1 && per < 1000)
            cyc(1);
        while (timeCarryPulseN === 1'b1 && per < 1000)
            cyc(1);
        while (timeCarryPulseN === 1'b0 && per < 1000)
        begin
            cyc(1);
            lo++;
            per++;
        end
        while (timeCarryPulseN === 1'b1 && per < 1000)
        begin
            cyc(1);
            per++;
        end
    endtask

    task automatic t_carry;
        int lo;
        int per;
        wr(network_time_sync_pkg::CARRY_LO_ADDR, 8'h01);
        carry_span(lo, per);
        check("carryLow", 16'(lo), 16'd32);
        check("carryPeriod", 16'(per), 16'd128);
    endtask

    task automatic t_lock;
        int dl[3] = '{0, 2, -2};
        logic [15:0] t0;
        wr(network_time_sync_pkg::MASTER_ID_ADDR, 8'h05);
        for (int i = 0; i < 3; i++)
        begin
            u_time_master_model.send(5'h05, auto_ofs(0, 0), dl[i]);
            cyc(1);
            check("unlock", syncUnlockFlag, 16'(i < 2));
        end
        u_time_master_model.send(5'h05, auto_ofs(0, 0), 3);
        cyc(1);
        check("unlock", syncUnlockFlag, 1);
        // +3 asks for a slower count: the next step is skipped, none lands in 40 clocks
        t0 = networkTime;
        cyc(40);
        check("slowTime", networkTime, t0);
        read_phase(16'h0003);
        u_time_master_model.send(5'h06, auto_ofs(0, 0), 9);
        read_phase(16'h0003);
    endtask

    task automatic t_offset;
        @(posedge clk);
        timePrescaleSel <= 3'b100;
        wr(network_time_sync_pkg::CARRY_HI_ADDR, 8'h87);
        u_time_master_model.send(5'h05, 7, -2);
        read_phase(16'h8002);
        @(posedge clk);
        timePrescaleSel <= 3'b000;
        bitRateSelect   <= 3'b001;
        u_time_master_model.send(5'h05, auto_ofs(1, 0), -1);
        read_phase(16'h8001);
    endtask

    task automatic t_master;
        wr(network_time_sync_pkg::MASTER_ID_ADDR, 8'h03);
        cyc(3);
        check("unlock", syncUnlockFlag, 0);
        @(posedge clk);
        swReset <= 1'b1;
        cyc(3);
        check("unlock", syncUnlockFlag, 1);
        @(posedge clk);
        swReset <= 1'b0;
        cyc(3);
        check("unlock", syncUnlockFlag, 0);
        check("intOut", interruptOutN, 1);
    endtask

    task automatic t_standalone;
        int lo;
        int per;
        @(posedge clk);
        rst            <= 1'b1;
        standaloneMode <= 1'b1;
        masterIdPins   <= 5'h03;
        carryDigitPins <= 4'h2;
        cyc(6);
        check("intOut", interruptOutN, 1);
        @(posedge clk);
        rst <= 1'b0;
        cyc(6);
        check("unlock", syncUnlockFlag, 0);
        check("intOut", interruptOutN, 0);
        // digit from the pins in standalone: eight steps of 32 clocks
        carry_span(lo, per);
        check("pinCarryLow", 16'(lo), 16'd32);
        check("pinCarryPeriod", 16'(per), 16'd256);
    endtask

    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        swReset = 1'b0;
        standaloneMode = 1'b0;
        masterIdPins = 5'h05;
        carryDigitPins = 4'h0;
        bitRateSelect = 3'b000;
        timePrescaleSel = 3'b000;
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
        errors = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_carry();
        t_lock();
        t_offset();
        t_master();
        t_standalone();
        finish_test();
    end

    // longest scenario needs several hundred cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
